// File: hdl/spc_agent.sv
// Agent end of a secondary port: requesters and a single target
`default_nettype none
module spc_agent
    import spc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_want_bus,
    input wire logic i_claim,
    input wire logic [2:0] i_claim_delay,
    input wire logic i_halt,
    input wire logic i_raise_fault,
    input wire logic [31:0] i_read_data,
    output logic [7:0] o_granted,
    output logic o_wr_valid,
    output logic [31:0] o_wr_data,
    output logic [31:0] o_addr,
    output logic o_locked,
    spc_bus_if.ag bus
);
    spc_tgt_t st;
    logic rd_q, halt_q, par_oe_q, par_q;
    logic [2:0] dly;
    assign bus.a_rq_o = ~i_want_bus;
    assign bus.a_sf_oe = i_raise_fault;
    assign o_granted = ~bus.bus_grant_n;
    assign o_locked = !bus.atomic_hold_n;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= SPC_T_IDLE;
            rd_q <= 1'b0;
            halt_q <= 1'b0;
            dly <= 3'h0;
            o_wr_valid <= 1'b0;
            o_wr_data <= 32'h0000_0000;
            o_addr <= 32'h0000_0000;
        end else if (i_ce) begin
            o_wr_valid <= 1'b0;
            if (!bus.bus_reset_n) begin
                st <= SPC_T_IDLE;
            end else begin
                case (st)
                    SPC_T_IDLE: begin
                        if (!bus.cycle_frame_n && bus.initiator_ready_n && i_claim) begin
                            o_addr <= bus.addr_data;
                            rd_q <= !bus.cmd_byte_en[0];
                            halt_q <= i_halt;
                            dly <= i_claim_delay;
                            st <= SPC_T_WAIT;
                        end
                    end
                    SPC_T_WAIT: begin
                        if (dly == 3'h0) begin
                            st <= SPC_T_DATA;
                        end else begin
                            dly <= dly - 3'h1;
                        end
                    end
                    SPC_T_DATA: begin
                        if (!bus.initiator_ready_n && (halt_q || !bus.target_ready_n)) begin
                            o_wr_valid <= !rd_q && !halt_q;
                            o_wr_data <= bus.addr_data;
                            st <= SPC_T_TURN;
                        end
                    end
                    SPC_T_TURN: begin
                        st <= SPC_T_IDLE;
                    end
                    default: begin
                        st <= SPC_T_IDLE;
                    end
                endcase
            end
        end
    end
    // Read parity follows the data by one clock
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            par_q <= 1'b0;
            par_oe_q <= 1'b0;
        end else if (i_ce) begin
            par_q <= ^{bus.a_dat_o, bus.cmd_byte_en};
            par_oe_q <= bus.a_dat_oe;
        end
    end
    logic claim_on;
    assign claim_on = st == SPC_T_DATA && bus.bus_reset_n;
    assign bus.a_cl_o = !claim_on;
    assign bus.a_cl_oe = claim_on || st == SPC_T_TURN;
    assign bus.a_tr_o = !(claim_on && !halt_q);
    assign bus.a_tr_oe = claim_on || st == SPC_T_TURN;
    assign bus.a_ht_o = !(claim_on && halt_q);
    assign bus.a_ht_oe = claim_on || st == SPC_T_TURN;
    assign bus.a_dat_o = i_read_data;
    assign bus.a_dat_oe = claim_on && rd_q && !halt_q;
    assign bus.a_pb_o = par_q;
    assign bus.a_pb_oe = par_oe_q && bus.bus_reset_n;
endmodule : spc_agent
`default_nettype wire

// File: hdl/spc_port_dev.sv
// Bridge end of one secondary port: initiator, arbiter, reset and clock outputs
`default_nettype none
module spc_port_dev
    import spc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_port_enable,
    input wire logic i_fast_bus_ok,
    input wire logic i_internal_arbiter_select_n,
    input wire logic i_sec_reset_ctl,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic i_req_lock,
    input wire logic [3:0] i_req_cmd,
    input wire logic [31:0] i_req_addr,
    input wire logic [31:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_done,
    output logic [31:0] o_rdata,
    output logic o_master_abort,
    output logic o_target_halted,
    output logic o_parity_fault,
    output logic o_system_fault_seen,
    output logic o_fast_bus,
    output logic o_ext_arbiter,
    spc_bus_if.dev bus
);
    // =====================================================
    // Straps and pins
    logic [3:0] sq;
    logic en_q, ext_q;
    spc_sync #(.W(4)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_d({i_port_enable, i_fast_bus_ok, i_internal_arbiter_select_n, ~bus.system_fault_n}),
        .o_q(sq)
    );
    assign en_q = sq[3];
    assign o_fast_bus = sq[2];
    assign ext_q = sq[1];
    assign o_ext_arbiter = ext_q;
    assign o_system_fault_seen = sq[0];

    logic brst;
    assign brst = i_sys_rst | i_sec_reset_ctl;

    // =====================================================
    // Arbiter
    spc_mst_t st;
    logic [8:0] gq, want;
    logic [1:0] gap;
    logic own_gnt, idle_bus, own_req;
    assign idle_bus = bus.cycle_frame_n & bus.initiator_ready_n;
    assign own_req = (st == SPC_M_WAIT);
    always_comb begin
        want = 9'h100;
        if (!own_req) begin
            for (int i = SPC_N_REQ - 1; i >= 0; i--) begin
                if (!bus.bus_request_n[i]) begin
                    want = 9'h000;
                    want[i] = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gq <= 9'h000;
            gap <= 2'h0;
        end else if (i_ce) begin
            if (brst || ext_q) begin
                gq <= 9'h000;
                gap <= 2'h0;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
                if (gap == 2'h1) begin
                    gq <= want;
                end
            end else if (idle_bus && gq != want) begin
                gq <= 9'h000;
                gap <= SPC_GNT_GAP_CLKS;
            end
        end
    end
    assign own_gnt = ext_q ? ~bus.bus_request_n[0] : gq[8];

    // =====================================================
    // Initiator
    logic wr_q, lock_want_q, seen_q, lk_q, lk_rel_q;
    logic [3:0] cmd_q;
    logic [31:0] addr_q, wd_q;
    logic [2:0] cnt;
    logic xfer;
    assign xfer = !bus.initiator_ready_n && !bus.target_ready_n;
    assign o_req_ready = (st == SPC_M_IDLE) && !brst;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= SPC_M_IDLE;
            wr_q <= 1'b0;
            lock_want_q <= 1'b0;
            cmd_q <= 4'h0;
            addr_q <= 32'h0000_0000;
            wd_q <= 32'h0000_0000;
            cnt <= 3'h0;
            seen_q <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_master_abort <= 1'b0;
            o_target_halted <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            o_master_abort <= 1'b0;
            o_target_halted <= 1'b0;
            if (brst) begin
                st <= SPC_M_IDLE;
            end else begin
                case (st)
                    SPC_M_IDLE: begin
                        if (i_req_valid) begin
                            wr_q <= i_req_write;
                            lock_want_q <= i_req_lock;
                            cmd_q <= i_req_cmd;
                            addr_q <= i_req_addr;
                            wd_q <= i_req_wdata;
                            st <= SPC_M_WAIT;
                        end
                    end
                    SPC_M_WAIT: begin
                        if (own_gnt && idle_bus && en_q) begin
                            st <= SPC_M_ADDR;
                        end
                    end
                    SPC_M_ADDR: begin
                        cnt <= 3'h1;
                        seen_q <= 1'b0;
                        st <= SPC_M_DATA;
                    end
                    SPC_M_DATA: begin
                        if (cnt != SPC_ABORT_CLKS) begin
                            cnt <= cnt + 3'h1;
                        end
                        if (!bus.target_claim_n) begin
                            seen_q <= 1'b1;
                        end
                        if (xfer) begin
                            o_rdata <= bus.addr_data;
                            o_done <= 1'b1;
                            st <= SPC_M_TURN;
                        end else if (!bus.target_halt_n) begin
                            o_target_halted <= 1'b1;
                            st <= SPC_M_TURN;
                        end else if (!seen_q && bus.target_claim_n && cnt == SPC_ABORT_CLKS) begin
                            o_master_abort <= 1'b1;
                            st <= SPC_M_TURN;
                        end
                    end
                    SPC_M_TURN: begin
                        st <= SPC_M_IDLE;
                    end
                    default: begin
                        st <= SPC_M_IDLE;
                    end
                endcase
            end
        end
    end

    // Atomic hold across transactions while the user keeps lock asserted
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lk_q <= 1'b0;
            lk_rel_q <= 1'b0;
        end else if (i_ce) begin
            lk_rel_q <= 1'b0;
            if (brst) begin
                lk_q <= 1'b0;
            end else if (st == SPC_M_ADDR && lock_want_q) begin
                lk_q <= 1'b1;
            end else if (lk_q && st == SPC_M_IDLE && !i_req_lock) begin
                lk_q <= 1'b0;
                lk_rel_q <= 1'b1;
            end
        end
    end

    // =====================================================
    // Parity generation and read checking
    logic park, dat_oe, be_oe, par_q, par_oe_q, chk_q, rx_q, pf_act, pf_rel;
    logic [31:0] dat;
    logic [3:0] be;
    assign park = own_gnt && idle_bus && (st == SPC_M_IDLE || st == SPC_M_WAIT);
    assign dat_oe = park || st == SPC_M_ADDR || (st == SPC_M_DATA && wr_q);
    assign be_oe = park || st == SPC_M_ADDR || st == SPC_M_DATA;
    assign dat = (st == SPC_M_ADDR) ? addr_q : (st == SPC_M_DATA) ? wd_q : SPC_PARK_DATA;
    assign be = (st == SPC_M_ADDR) ? cmd_q : (st == SPC_M_DATA) ? SPC_BE_ALL : SPC_PARK_BE;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            par_q <= 1'b0;
            par_oe_q <= 1'b0;
            chk_q <= 1'b0;
            rx_q <= 1'b0;
            pf_act <= 1'b0;
            pf_rel <= 1'b0;
            o_parity_fault <= 1'b0;
        end else if (i_ce) begin
            par_q <= ^{dat, be};
            par_oe_q <= dat_oe && !brst;
            chk_q <= !brst && st == SPC_M_DATA && xfer && !wr_q;
            rx_q <= ^{bus.addr_data, bus.cmd_byte_en};
            pf_act <= chk_q && (rx_q != bus.parity_bit);
            pf_rel <= pf_act;
            o_parity_fault <= chk_q && (rx_q != bus.parity_bit);
        end
    end

    // =====================================================
    // Pin drives: reset zeros data lines, enable low floats everything
    logic ctl;
    assign ctl = i_port_enable && !brst;
    assign bus.d_fr_o = !(st == SPC_M_ADDR);
    assign bus.d_fr_oe = ctl && (st == SPC_M_ADDR || st == SPC_M_DATA);
    assign bus.d_ir_o = !(st == SPC_M_DATA);
    assign bus.d_ir_oe = ctl && (st == SPC_M_DATA || st == SPC_M_TURN);
    assign bus.d_ah_o = !lk_q;
    assign bus.d_ah_oe = ctl && (lk_q || lk_rel_q);
    assign bus.d_pf_o = !pf_act;
    assign bus.d_pf_oe = ctl && (pf_act || pf_rel);
    assign bus.d_dat_o = brst ? 32'h0000_0000 : dat;
    assign bus.d_dat_oe = i_port_enable && (brst || dat_oe);
    assign bus.d_be_o = brst ? 4'h0 : be;
    assign bus.d_be_oe = i_port_enable && (brst || be_oe);
    assign bus.d_pb_o = brst ? 1'b0 : par_q;
    assign bus.d_pb_oe = i_port_enable && (brst || par_oe_q);
    assign bus.d_gr_o = ext_q ? {7'h7F, ~own_req} : ~gq[7:0];
    assign bus.d_gr_oe = ctl;
    assign bus.d_rs_o = !brst;
    assign bus.d_rs_oe = i_port_enable;
    assign bus.d_ck_o = {SPC_N_CLK{i_clk_sys}};
    assign bus.d_ck_oe = i_port_enable;
endmodule : spc_port_dev
`default_nettype wire

// File: hdl/spc_sync.sv
// Two-flop synchroniser for straps and asynchronous pins
`default_nettype none
module spc_sync #(
    parameter int W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta <= '0;
            o_q <= '0;
        end else if (i_ce) begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule : spc_sync
`default_nettype wire

// File: include/spc_bus_if.sv
// Secondary bus wires with per-party drives and pull-up resolution; undriven clock outputs resolve low
`default_nettype none
interface spc_bus_if;
    logic d_fr_o, d_fr_oe, d_ir_o, d_ir_oe, d_ah_o, d_ah_oe, d_pf_o, d_pf_oe;
    logic d_pb_o, d_pb_oe, d_dat_oe, d_be_oe, d_gr_oe, d_rs_o, d_rs_oe, d_ck_oe;
    logic [31:0] d_dat_o;
    logic [3:0] d_be_o;
    logic [7:0] d_gr_o, d_ck_o;
    logic a_tr_o, a_tr_oe, a_cl_o, a_cl_oe, a_ht_o, a_ht_oe, a_pb_o, a_pb_oe;
    logic a_sf_oe, a_dat_oe;
    logic [31:0] a_dat_o;
    logic [7:0] a_rq_o;
    logic cycle_frame_n, initiator_ready_n, target_ready_n, target_claim_n;
    logic target_halt_n, atomic_hold_n, parity_fault_n, system_fault_n;
    logic parity_bit, bus_reset_n;
    logic [31:0] addr_data;
    logic [3:0] cmd_byte_en;
    logic [7:0] bus_request_n, bus_grant_n, clock_outputs;
    assign cycle_frame_n = d_fr_oe ? d_fr_o : 1'b1;
    assign initiator_ready_n = d_ir_oe ? d_ir_o : 1'b1;
    assign atomic_hold_n = d_ah_oe ? d_ah_o : 1'b1;
    assign parity_fault_n = d_pf_oe ? d_pf_o : 1'b1;
    assign target_ready_n = a_tr_oe ? a_tr_o : 1'b1;
    assign target_claim_n = a_cl_oe ? a_cl_o : 1'b1;
    assign target_halt_n = a_ht_oe ? a_ht_o : 1'b1;
    assign system_fault_n = a_sf_oe ? 1'b0 : 1'b1;
    assign addr_data = d_dat_oe ? d_dat_o : (a_dat_oe ? a_dat_o : 32'hFFFF_FFFF);
    assign parity_bit = d_pb_oe ? d_pb_o : (a_pb_oe ? a_pb_o : 1'b1);
    assign cmd_byte_en = d_be_oe ? d_be_o : 4'hF;
    assign bus_request_n = a_rq_o;
    assign bus_grant_n = d_gr_oe ? d_gr_o : 8'hFF;
    assign bus_reset_n = d_rs_oe ? d_rs_o : 1'b1;
    assign clock_outputs = d_ck_oe ? d_ck_o : 8'h00;
    modport dev (
        output d_fr_o, d_fr_oe, d_ir_o, d_ir_oe, d_ah_o, d_ah_oe, d_pf_o, d_pf_oe, d_pb_o, d_pb_oe,
        output d_dat_o, d_dat_oe, d_be_o, d_be_oe, d_gr_o, d_gr_oe, d_rs_o, d_rs_oe, d_ck_o, d_ck_oe,
        input cycle_frame_n, initiator_ready_n, target_ready_n, target_claim_n, target_halt_n,
        input system_fault_n, addr_data, cmd_byte_en, parity_bit, bus_request_n
    );
    modport ag (
        output a_tr_o, a_tr_oe, a_cl_o, a_cl_oe, a_ht_o, a_ht_oe, a_pb_o, a_pb_oe, a_sf_oe,
        output a_dat_o, a_dat_oe, a_rq_o,
        input cycle_frame_n, initiator_ready_n, target_ready_n, addr_data, cmd_byte_en,
        input bus_grant_n, bus_reset_n, atomic_hold_n
    );
endinterface : spc_bus_if
`default_nettype wire

// File: include/spc_pkg.sv
// Shared constants and types for the secondary PCI port control block
// How it works
// - Initiator holds its ready until data phase ends
// - Target holds its ready until data phase ends
// - Drive inactive one clock before release
// - Target claims access by asserting claim low
// - Master abort without claim in 5 clocks
// - Target halt request is honoured by initiator
// - Atomic hold stays low across locked sequence
// - Parity fault low on bad received data
// - System fault line is driven by agents only
// - Agents request bus over eight request lines
// - Removed grant stays off two clocks minimum
// - Idle bus with own grant is parked
// - Bus reset from primary reset or control bit
// - Reset tri-states controls, zeros data lines
// - Port enable low tri-states all outputs at once
// - Fast bus input allows 66MHz, else 33MHz
// - Strap low selects internal arbiter
// - Strap high swaps line zero for external arbiter
// - Eight clock outputs follow the primary clock
// - Word moves when both readies low
// - Frame high marks last phase, driven before release
// - Even parity over data, enables and parity
`default_nettype none
package spc_pkg;
    localparam int SPC_N_REQ = 8;
    localparam int SPC_N_CLK = 8;
    localparam logic [2:0] SPC_ABORT_CLKS = 3'h5;
    localparam logic [1:0] SPC_GNT_GAP_CLKS = 2'h2;
    localparam logic [3:0] SPC_BE_ALL = 4'h0;
    localparam logic [31:0] SPC_PARK_DATA = 32'h0000_0000;
    localparam logic [3:0] SPC_PARK_BE = 4'h0;
    typedef enum logic [2:0] {
        SPC_M_IDLE = 3'b000,
        SPC_M_WAIT = 3'b001,
        SPC_M_ADDR = 3'b010,
        SPC_M_DATA = 3'b011,
        SPC_M_TURN = 3'b100
    } spc_mst_t;
    typedef enum logic [1:0] {
        SPC_T_IDLE = 2'b00,
        SPC_T_WAIT = 2'b01,
        SPC_T_DATA = 2'b10,
        SPC_T_TURN = 2'b11
    } spc_tgt_t;
endpackage : spc_pkg
`default_nettype wire

// File: verif/spc_props.sv
// Concurrent checks on the resolved secondary bus and the bridge-end drives
`default_nettype none
module spc_props (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic cycle_frame_n,
    input wire logic initiator_ready_n,
    input wire logic target_ready_n,
    input wire logic target_claim_n,
    input wire logic target_halt_n,
    input wire logic parity_fault_n,
    input wire logic bus_reset_n,
    input wire logic [7:0] bus_grant_n,
    input wire logic [31:0] addr_data,
    input wire logic [3:0] cmd_byte_en,
    input wire logic parity_bit,
    input wire logic d_fr_o,
    input wire logic d_fr_oe,
    input wire logic d_ir_o,
    input wire logic d_ir_oe,
    input wire logic d_pf_oe,
    input wire logic d_pb_o,
    input wire logic d_pb_oe,
    input wire logic [31:0] d_dat_o,
    input wire logic d_dat_oe,
    input wire logic [3:0] d_be_o,
    input wire logic d_be_oe
);
    // ==========================================
    // Sequences
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_ir_end;
        (d_ir_oe && !d_ir_o) ##1 (d_ir_oe && d_ir_o);
    endsequence
    sequence s_no_claim;
        $fell(cycle_frame_n) ##0 target_claim_n [*6];
    endsequence
    sequence s_grant_drop;
        (bus_grant_n != 8'hFF) ##1 (bus_grant_n == 8'hFF);
    endsequence
    // ==========================================
    // Assertions
    chk_initiator_hold: assert property (
        $rose(initiator_ready_n) |-> !$past(target_ready_n) || !$past(target_halt_n) || $past(target_claim_n))
        else $error("initiator ready dropped before phase end");
    chk_target_hold: assert property (
        $rose(target_ready_n) |-> !$past(initiator_ready_n))
        else $error("target ready dropped before phase end");
    chk_ready_release: assert property (s_ir_end |=> !d_ir_oe)
        else $error("initiator ready not released after one high clock");
    chk_frame_release: assert property ($fell(d_fr_oe) |-> $past(d_fr_o))
        else $error("frame released while low");
    chk_fault_pulse: assert property (
        $fell(parity_fault_n) |=> (parity_fault_n && d_pf_oe) ##1 !d_pf_oe)
        else $error("parity fault release sequence wrong");
    chk_abort_time: assert property (s_no_claim |=> initiator_ready_n)
        else $error("no master abort after unclaimed frame");
    chk_frame_last: assert property (
        $fell(cycle_frame_n) |=> cycle_frame_n && !initiator_ready_n)
        else $error("frame not raised for the single data phase");
    chk_grant_gap: assert property (s_grant_drop |=> bus_grant_n == 8'hFF)
        else $error("grant gap shorter than two clocks");
    chk_reset_float: assert property (
        !bus_reset_n |-> !d_fr_oe && !d_ir_oe && addr_data == 32'h0000_0000 && cmd_byte_en == 4'h0 && !parity_bit)
        else $error("bus reset does not float controls and zero data");
    chk_even_parity: assert property (
        d_pb_oe && $past(d_dat_oe) && $past(d_be_oe) |-> d_pb_o == ^{$past(d_dat_o), $past(d_be_o)})
        else $error("parity bit not even over data and enables");
endmodule : spc_props
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench joining the bridge end and the agent end of one port
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module testbench
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, one, en, fast, arb_n, srst, rv, rw, rl, rready, done, mabort, thalt;
    logic pfault, sfault, fast_q, ext_q, claim, halt, raise, wr_valid, locked;
    logic [3:0] rcmd;
    logic [31:0] raddr, rwd, rdata, wr_data, a_addr, rd_in;
    logic [7:0] want, granted;
    logic [2:0] cdel;
    logic [3:0] res;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    spc_bus_if bus_if ();
    spc_port_dev spc_port_dev_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(one), .i_port_enable(en),
        .i_fast_bus_ok(fast), .i_internal_arbiter_select_n(arb_n), .i_sec_reset_ctl(srst), .i_req_valid(rv),
        .i_req_write(rw), .i_req_lock(rl), .i_req_cmd(rcmd), .i_req_addr(raddr), .i_req_wdata(rwd),
        .o_req_ready(rready), .o_done(done), .o_rdata(rdata), .o_master_abort(mabort), .o_target_halted(thalt),
        .o_parity_fault(pfault), .o_system_fault_seen(sfault), .o_fast_bus(fast_q), .o_ext_arbiter(ext_q),
        .bus(bus_if.dev));
    spc_agent spc_agent_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(one), .i_want_bus(want), .i_claim(claim),
        .i_claim_delay(cdel), .i_halt(halt), .i_raise_fault(raise), .i_read_data(rd_in), .o_granted(granted),
        .o_wr_valid(wr_valid), .o_wr_data(wr_data), .o_addr(a_addr), .o_locked(locked), .bus(bus_if.ag));
    spc_props spc_props_inst (.i_clk_sys(clk), .i_sys_rst(rst), .cycle_frame_n(bus_if.cycle_frame_n),
        .initiator_ready_n(bus_if.initiator_ready_n), .target_ready_n(bus_if.target_ready_n),
        .target_claim_n(bus_if.target_claim_n), .target_halt_n(bus_if.target_halt_n),
        .parity_fault_n(bus_if.parity_fault_n), .bus_reset_n(bus_if.bus_reset_n), .bus_grant_n(bus_if.bus_grant_n),
        .addr_data(bus_if.addr_data), .cmd_byte_en(bus_if.cmd_byte_en), .parity_bit(bus_if.parity_bit),
        .d_fr_o(bus_if.d_fr_o), .d_fr_oe(bus_if.d_fr_oe), .d_ir_o(bus_if.d_ir_o), .d_ir_oe(bus_if.d_ir_oe),
        .d_pf_oe(bus_if.d_pf_oe), .d_pb_o(bus_if.d_pb_o), .d_pb_oe(bus_if.d_pb_oe), .d_dat_o(bus_if.d_dat_o),
        .d_dat_oe(bus_if.d_dat_oe), .d_be_o(bus_if.d_be_o), .d_be_oe(bus_if.d_be_oe));
    // ==========================================
    // Clock, timeout and access tasks
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic step();
        @(posedge clk);
        #5;
    endtask : step
    // Request held until the edge that sees ready
    task automatic start(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        rv = 1'b1;
        rw = wr;
        rcmd = wr ? 4'h7 : 4'h6;
        raddr = adr;
        rwd = wd;
        while (rready !== 1'b1 && n < 50) begin
            step();
            n++;
        end
        step();
        rv = 1'b0;
    endtask : start
    task automatic finish_x();
        int n;
        n = 0;
        res = {wr_valid, done, mabort, thalt};
        while (res === 4'h0 && n < 40) begin
            step();
            res = {wr_valid, done, mabort, thalt};
            n++;
        end
        step();
    endtask : finish_x
    task automatic wait_grant(input logic [7:0] exp);
        int n;
        n = 0;
        while (granted !== exp && n < 30) begin
            step();
            n++;
        end
        `CHK("grant", exp, granted)
    endtask : wait_grant
    // ==========================================
    // Scenarios
    initial begin
        {one, en, fast, claim} = 4'hF;
        {arb_n, srst, rv, rw, rl, halt, raise} = 7'h00;
        {rcmd, raddr, rwd, want, cdel} = 79'h0;
        rd_in = 32'hA5A5_0F0F;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        #5;
        rst = 1'b0;
        step();
        start(1'b1, 32'h0000_1000, 32'hDEAD_BEEF);
        finish_x();
        `CHK("write outcome", 4'hC, res)
        `CHK("write data", 32'hDEAD_BEEF, wr_data)
        `CHK("claimed address", 32'h0000_1000, a_addr)
        for (int d = 0; d < 4; d++) begin
            cdel = d[2:0];
            rd_in = {28'h1234_567, d[3:0]};
            start(1'b0, 32'h0000_2000, 32'h0000_0000);
            finish_x();
            `CHK("read outcome", 4'h4, res)
            `CHK("read data", {28'h1234_567, d[3:0]}, rdata)
            `CHK("read parity fault", 1'b0, pfault)
        end
        claim = 1'b0;
        start(1'b1, 32'h0000_3000, 32'h0000_0001);
        finish_x();
        `CHK("abort outcome", 4'h2, res)
        claim = 1'b1;
        halt = 1'b1;
        start(1'b0, 32'h0000_3004, 32'h0000_0000);
        finish_x();
        `CHK("halt outcome", 4'h1, res)
        halt = 1'b0;
        rl = 1'b1;
        start(1'b1, 32'h0000_4000, 32'h0000_0002);
        finish_x();
        `CHK("lock held", 1'b0, bus_if.atomic_hold_n)
        `CHK("agent locked", 1'b1, locked)
        rl = 1'b0;
        start(1'b1, 32'h0000_4004, 32'h0000_0003);
        finish_x();
        repeat (3) step();
        `CHK("lock released", 1'b1, bus_if.atomic_hold_n)
        raise = 1'b1;
        repeat (4) step();
        `CHK("system fault seen", 1'b1, sfault)
        raise = 1'b0;
        repeat (4) step();
        `CHK("system fault gone", 1'b0, sfault)
        for (int f = 0; f < 2; f++) begin
            fast = f[0];
            repeat (4) step();
            `CHK("fast bus", f[0], fast_q)
        end
        want = 8'h84;
        wait_grant(8'h04);
        want = 8'h80;
        wait_grant(8'h80);
        want = 8'h00;
        repeat (6) step();
        `CHK("park data", SPC_PARK_DATA, bus_if.addr_data)
        `CHK("park enables", SPC_PARK_BE, bus_if.cmd_byte_en)
        `CHK("clock high", 8'hFF, bus_if.clock_outputs)
        #50;
        `CHK("clock low", 8'h00, bus_if.clock_outputs)
        step();
        srst = 1'b1;
        step();
        `CHK("bus reset", 1'b0, bus_if.bus_reset_n)
        `CHK("reset data", 32'h0000_0000, bus_if.addr_data)
        `CHK("reset ready", 1'b0, rready)
        srst = 1'b0;
        repeat (3) step();
        en = 1'b0;
        #1;
        `CHK("float data", 32'hFFFF_FFFF, bus_if.addr_data)
        step();
        en = 1'b1;
        repeat (5) step();
        arb_n = 1'b1;
        repeat (4) step();
        `CHK("external mode", 1'b1, ext_q)
        start(1'b1, 32'h0000_5000, 32'h0000_0005);
        repeat (3) step();
        `CHK("device request", 1'b0, bus_if.bus_grant_n[0])
        `CHK("waits for grant", 1'b1, bus_if.cycle_frame_n)
        want = 8'h01;
        finish_x();
        `CHK("external outcome", 4'hC, res)
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
